// *** lfsc_frame_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module lfsc_frame_src (
	input  wire logic core_clk,
	output var  logic host_v,
	output var  logic lower_v,
	output var  logic upper_v
);
	initial begin
		host_v = 1'b0;
		lower_v = 1'b0;
		upper_v = 1'b0;
	end

	// Sends back-to-back one-cycle frame pulses, the densest load the ports can see.
	task automatic send(input int h, input int l, input int u);
		int i;
		for (i = 0; i < h || i < l || i < u; i++) begin
			@(posedge core_clk);
			host_v <= (i < h);
			lower_v <= (i < l);
			upper_v <= (i < u);
		end
		@(posedge core_clk);
		host_v <= 1'b0;
		lower_v <= 1'b0;
		upper_v <= 1'b0;
	endtask
endmodule // lfsc_frame_src

`default_nettype wire

// *** link_frame_stat_counters.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_frame_stat_counters_map.svh"

module link_frame_stat_counters #(
	parameter int ADDR_WIDTH = 12
) (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  host_frame_valid,
	input  wire logic                  lower_frame_valid,
	input  wire logic                  upper_frame_valid,
	input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output var  logic                  s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output var  logic                  s_axi_wready,
	output var  logic [1:0]            s_axi_bresp,
	output var  logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output var  logic                  s_axi_arready,
	output var  logic [31:0]           s_axi_rdata,
	output var  logic [1:0]            s_axi_rresp,
	output var  logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready
);

	localparam int NPORT = int'(link_frame_stat_counters_pkg::PORT_COUNT);

	// ------------------------------------------------------------------------
	// Read address decode.
	// ------------------------------------------------------------------------
	link_frame_stat_counters_pkg::reg_index_t rd_index;
	logic                                     rd_take;
	logic [NPORT-1:0]                         frame_valid;
	logic [NPORT-1:0]                         snap_take;
	logic [NPORT-1:0]                         count_en_reg;
	logic [NPORT-1:0]                         count_en_next;
	link_frame_stat_counters_pkg::count_t     snap_all [NPORT];

	assign rd_index    = s_axi_araddr[11:2];
	assign rd_take     = s_axi_arvalid && s_axi_arready;
	assign frame_valid = {upper_frame_valid, lower_frame_valid, host_frame_valid};
	assign snap_take[int'(link_frame_stat_counters_pkg::PORT_HOST)]  =
		rd_take && (rd_index == `LFSC_IDX_HOST_SNAP);
	assign snap_take[int'(link_frame_stat_counters_pkg::PORT_LOWER)] =
		rd_take && (rd_index == `LFSC_IDX_LOWER_SNAP);
	assign snap_take[int'(link_frame_stat_counters_pkg::PORT_UPPER)] =
		rd_take && (rd_index == `LFSC_IDX_UPPER_SNAP);

	// ------------------------------------------------------------------------
	// Per-port live counter and snapshot.
	// ------------------------------------------------------------------------
	// A frame arriving in the snapshot cycle is counted into the new interval.
	for (genvar g = 0; g < NPORT; g++) begin : port_gen
		link_frame_stat_counters_pkg::count_t live_reg;
		link_frame_stat_counters_pkg::count_t live_next;
		link_frame_stat_counters_pkg::count_t snap_reg;
		link_frame_stat_counters_pkg::count_t snap_next;
		logic                                 bump;

		always_comb begin
			bump      = frame_valid[g] && count_en_reg[g];
			live_next = live_reg;
			snap_next = snap_reg;
			if (snap_take[g]) begin
				snap_next = live_reg;
				live_next = bump ? 16'h0001 : `LFSC_COUNT_RESET;
			end else if (bump && (live_reg != `LFSC_COUNT_MAX)) begin
				live_next = live_reg + 16'h0001;
			end
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				live_reg <= `LFSC_COUNT_RESET;
				snap_reg <= `LFSC_COUNT_RESET;
			end else begin
				live_reg <= live_next;
				snap_reg <= snap_next;
			end
		end

		assign snap_all[g] = snap_reg;
	end

	// ------------------------------------------------------------------------
	// Read channel.
	// ------------------------------------------------------------------------
	logic        arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [7:0]  rd_byte;
	logic        rd_hit;

	always_comb begin
		rd_byte = `LFSC_BYTE_RESET;
		rd_hit  = 1'b1;
		case (rd_index)
			`LFSC_IDX_HOST_HI:    rd_byte = snap_all[0][15:8];
			`LFSC_IDX_HOST_LO:    rd_byte = snap_all[0][7:0];
			`LFSC_IDX_LOWER_HI:   rd_byte = snap_all[1][15:8];
			`LFSC_IDX_LOWER_LO:   rd_byte = snap_all[1][7:0];
			`LFSC_IDX_UPPER_HI:   rd_byte = snap_all[2][15:8];
			`LFSC_IDX_UPPER_LO:   rd_byte = snap_all[2][7:0];
			`LFSC_IDX_HOST_SNAP,
			`LFSC_IDX_LOWER_SNAP,
			`LFSC_IDX_UPPER_SNAP: rd_byte = `LFSC_BYTE_RESET;
			`LFSC_IDX_COUNT_EN:   rd_byte = {5'h00, count_en_reg};
			default:              rd_hit  = 1'b0;
		endcase
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (rd_take) begin
			rvalid_next = 1'b1;
			rdata_next  = {24'h000000, rd_byte};
			rresp_next  = rd_hit ? `LFSC_RESP_OKAY : `LFSC_RESP_DECERR;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= `LFSC_RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// ------------------------------------------------------------------------
	// Write channel.
	// ------------------------------------------------------------------------
	// Address and data are captured separately; the write acts once both are held.
	logic                                     aw_held_reg, aw_held_next;
	logic                                     w_held_reg, w_held_next;
	link_frame_stat_counters_pkg::reg_index_t aw_index_reg, aw_index_next;
	logic [7:0]                               wbyte_reg, wbyte_next;
	logic                                     wlane_reg, wlane_next;
	logic                                     awready_reg, awready_next;
	logic                                     wready_reg, wready_next;
	logic                                     bvalid_reg, bvalid_next;
	logic [1:0]                               bresp_reg, bresp_next;
	logic                                     wr_hit;

	always_comb begin
		aw_held_next  = aw_held_reg;
		w_held_next   = w_held_reg;
		aw_index_next = aw_index_reg;
		wbyte_next    = wbyte_reg;
		wlane_next    = wlane_reg;
		bvalid_next   = bvalid_reg;
		bresp_next    = bresp_reg;
		count_en_next = count_en_reg;
		wr_hit        = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			aw_held_next  = 1'b1;
			aw_index_next = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wbyte_next  = s_axi_wdata[7:0];
			wlane_next  = s_axi_wstrb[0];
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_held_reg && w_held_reg && !bvalid_reg) begin
			case (aw_index_reg)
				`LFSC_IDX_HOST_HI, `LFSC_IDX_HOST_LO, `LFSC_IDX_LOWER_HI,
				`LFSC_IDX_LOWER_LO, `LFSC_IDX_UPPER_HI, `LFSC_IDX_UPPER_LO,
				`LFSC_IDX_HOST_SNAP, `LFSC_IDX_LOWER_SNAP,
				`LFSC_IDX_UPPER_SNAP: wr_hit = 1'b1;
				`LFSC_IDX_COUNT_EN: begin
					wr_hit = 1'b1;
					if (wlane_reg) begin
						count_en_next = wbyte_reg[2:0];
					end
				end
				default: wr_hit = 1'b0;
			endcase
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? `LFSC_RESP_OKAY : `LFSC_RESP_DECERR;
		end
		awready_next = !aw_held_next && !bvalid_next;
		wready_next  = !w_held_next && !bvalid_next;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_index_reg <= 10'h000;
			wbyte_reg    <= `LFSC_BYTE_RESET;
			wlane_reg    <= 1'b0;
			awready_reg  <= 1'b0;
			wready_reg   <= 1'b0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= `LFSC_RESP_OKAY;
			count_en_reg <= `LFSC_COUNT_EN_RESET;
		end else begin
			aw_held_reg  <= aw_held_next;
			w_held_reg   <= w_held_next;
			aw_index_reg <= aw_index_next;
			wbyte_reg    <= wbyte_next;
			wlane_reg    <= wlane_next;
			awready_reg  <= awready_next;
			wready_reg   <= wready_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			count_en_reg <= count_en_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

endmodule // link_frame_stat_counters

`default_nettype wire

// *** link_frame_stat_counters_map.svh ***
`ifndef LINK_FRAME_STAT_COUNTERS_MAP_SVH
`define LINK_FRAME_STAT_COUNTERS_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define LFSC_IDX_HOST_HI      10'h26b
`define LFSC_IDX_HOST_LO      10'h26c
`define LFSC_IDX_LOWER_HI     10'h26d
`define LFSC_IDX_LOWER_LO     10'h26e
`define LFSC_IDX_UPPER_HI     10'h26f
`define LFSC_IDX_UPPER_LO     10'h270
`define LFSC_IDX_HOST_SNAP    10'h2a0
`define LFSC_IDX_LOWER_SNAP   10'h2a1
`define LFSC_IDX_UPPER_SNAP   10'h2a2
`define LFSC_IDX_COUNT_EN     10'h2a3

// ----------------------------------------------------------------------------
// Count limit and reset values.
// ----------------------------------------------------------------------------
`define LFSC_COUNT_MAX        16'hffff
`define LFSC_COUNT_RESET      16'h0000
`define LFSC_COUNT_EN_RESET   3'h7
`define LFSC_BYTE_RESET       8'h00

// ----------------------------------------------------------------------------
// AXI response codes.
// ----------------------------------------------------------------------------
`define LFSC_RESP_OKAY        2'h0
`define LFSC_RESP_DECERR      2'h3

`endif

// *** link_frame_stat_counters_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_frame_stat_counters_map.svh"

module link_frame_stat_counters_monitor #(
	parameter int ADDR_WIDTH = 12
) (
	input wire logic                  core_clk,
	input wire logic                  reset,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [9:0] idx;
	logic       is_cnt;
	logic       is_snap;
	assign idx = s_axi_araddr[11:2];
	assign is_cnt = idx inside {[`LFSC_IDX_HOST_HI:`LFSC_IDX_UPPER_LO]};
	assign is_snap = idx inside {[`LFSC_IDX_HOST_SNAP:`LFSC_IDX_UPPER_SNAP]};
	sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence

	chk_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read not answered");
	chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp)) else $error("read answer dropped early");
	chk_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
	chk_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write late");
	chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	chk_reset_idle: assert property (disable iff (1'b0) reset |=> !s_axi_rvalid && !s_axi_bvalid && !s_axi_arready)
		else $error("bus not idle in reset");
	chk_unmapped_err: assert property (ar_take ##0 !(is_cnt || is_snap || idx == `LFSC_IDX_COUNT_EN)
		|=> s_axi_rresp == `LFSC_RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	chk_byte_field: assert property (ar_take ##0 is_cnt |=> s_axi_rresp == `LFSC_RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
		else $error("count byte read malformed");
	chk_snap_zero: assert property (ar_take ##0 is_snap |=> s_axi_rdata == 32'h0)
		else $error("snapshot read not zero");
endmodule // link_frame_stat_counters_monitor

bind link_frame_stat_counters link_frame_stat_counters_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
	.core_clk(core_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

`default_nettype wire

// *** link_frame_stat_counters_pkg.sv ***
`default_nettype none

package link_frame_stat_counters_pkg;
	typedef logic [15:0] count_t;
	typedef logic [9:0]  reg_index_t;
	typedef enum {PORT_HOST, PORT_LOWER, PORT_UPPER, PORT_COUNT} port_t;
endpackage

`default_nettype wire

// *** link_frame_stat_counters_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_frame_stat_counters_map.svh"
`define CHK(nm, e, g) n_tests++; if ((g) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", nm, e, g); mismatches++; end

module link_frame_stat_counters_tb;
	logic core_clk = 0, reset = 1, hv, lv, uv, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, awr, wr_, bv, arr, rv;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat, d;
	logic [1:0]  bresp, rresp, r;
	int mismatches = 0, n_tests = 0, k, p;
	logic [9:0] snap_i[3] = '{`LFSC_IDX_HOST_SNAP, `LFSC_IDX_LOWER_SNAP, `LFSC_IDX_UPPER_SNAP};
	logic [9:0] hi_i[3] = '{`LFSC_IDX_HOST_HI, `LFSC_IDX_LOWER_HI, `LFSC_IDX_UPPER_HI};
	int rows[3][3] = '{'{1, 2, 3}, '{300, 0, 257}, '{0, 511, 1}};

	always #12.5 core_clk = ~core_clk;
	lfsc_frame_src u_src (.core_clk(core_clk), .host_v(hv), .lower_v(lv), .upper_v(uv));
	link_frame_stat_counters #(.ADDR_WIDTH(12)) u_dut (.core_clk(core_clk), .reset(reset), .host_frame_valid(hv),
		.lower_frame_valid(lv), .upper_frame_valid(uv), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd));

	task automatic close_out();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic give_up(input int i);
		if (i >= 200) begin
			mismatches++;
			close_out();
		end
	endtask

	task automatic rd(input logic [9:0] ix);
		int i;
		@(posedge core_clk);
		ara <= {ix, 2'b00};
		arv <= 1;
		rrd <= 1;
		i = 0;
		do begin @(posedge core_clk); i++; end while (arr !== 1'b1 && i < 200);
		give_up(i);
		arv <= 0;
		i = 0;
		do begin @(posedge core_clk); i++; end while (rv !== 1'b1 && i < 200);
		give_up(i);
		d = rdat;
		r = rresp;
		rrd <= 0;
	endtask

	task automatic wr(input logic [9:0] ix, input logic [31:0] v);
		int i;
		bit a, w;
		@(posedge core_clk);
		awa <= {ix, 2'b00};
		wd <= v;
		awv <= 1;
		wv <= 1;
		brd <= 1;
		a = 0;
		w = 0;
		for (i = 0; !(a && w) && i < 200; i++) begin
			@(posedge core_clk);
			if (awr === 1'b1) begin a = 1; awv <= 0; end
			if (wr_ === 1'b1) begin w = 1; wv <= 0; end
		end
		give_up(i);
		i = 0;
		do begin @(posedge core_clk); i++; end while (bv !== 1'b1 && i < 200);
		give_up(i);
		r = bresp;
		brd <= 0;
	endtask

	// Optionally takes a snapshot of port q, then reads its high and low count bytes.
	task automatic rd_cnt(input int q, input logic [15:0] e, input bit snap);
		if (snap) begin
			rd(snap_i[q]);
			`CHK("snapshot", 32'h0, d)
		end
		rd(hi_i[q]);
		`CHK("count hi", {24'h0, e[15:8]}, d)
		rd(hi_i[q] + 10'h1);
		`CHK("count lo", {24'h0, e[7:0]}, d)
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 0;
		for (p = 0; p < 3; p++) rd_cnt(p, 16'h0, 0);
		for (k = 0; k < 3; k++) begin
			u_src.send(rows[k][0], rows[k][1], rows[k][2]);
			for (p = 0; p < 3; p++) rd_cnt(p, rows[k][p], 1);
		end
		u_src.send(5, 65537, 65537);
		rd_cnt(0, 16'h5, 1);
		rd_cnt(1, 16'hffff, 1);
		rd_cnt(2, 16'hffff, 1);
		u_src.send(0, 3, 0);
		rd_cnt(1, 16'hffff, 0);
		rd_cnt(1, 16'h3, 1);
		rd(10'h0);
		`CHK("unmapped rresp", `LFSC_RESP_DECERR, r)
		`CHK("unmapped rdata", 32'h0, d)
		wr(`LFSC_IDX_LOWER_LO, 32'hff);
		`CHK("ro write bresp", `LFSC_RESP_OKAY, r)
		rd_cnt(1, 16'h3, 0);
		// With the lower port disabled its frames must not be counted.
		wr(`LFSC_IDX_COUNT_EN, 32'h5);
		`CHK("enable bresp", `LFSC_RESP_OKAY, r)
		rd(`LFSC_IDX_COUNT_EN);
		`CHK("enable readback", 32'h5, d)
		u_src.send(0, 4, 0);
		rd_cnt(1, 16'h0, 1);
		wr(`LFSC_IDX_COUNT_EN, 32'h7);
		// A frame that meets the snapshot edge must land in the new interval, not vanish.
		fork
			u_src.send(0, 40, 0);
			begin
				repeat (10) @(posedge core_clk);
				rd(`LFSC_IDX_LOWER_SNAP);
			end
		join
		rd(`LFSC_IDX_LOWER_LO);
		`CHK("split first", 32'h0a, d)
		rd(`LFSC_IDX_LOWER_SNAP);
		rd(`LFSC_IDX_LOWER_LO);
		`CHK("split second", 32'h1e, d)
		// A reset in mid-run clears counts and snapshots and sets the enable mask back to 7.
		u_src.send(3, 3, 3);
		wr(`LFSC_IDX_COUNT_EN, 32'h0);
		@(posedge core_clk);
		reset <= 1;
		repeat (2) @(posedge core_clk);
		reset <= 0;
		rd(`LFSC_IDX_COUNT_EN);
		`CHK("enable after reset", 32'h7, d)
		rd_cnt(1, 16'h0, 0);
		for (p = 0; p < 3; p++) rd_cnt(p, 16'h0, 1);
		close_out();
	end
endmodule // link_frame_stat_counters_tb

`default_nettype wire
